// file: hdl/ccp_cfg.svh
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// Operation word fields
`define CCP_FLINE_PATTERN   4'hf
`define CCP_KIND_SET        3'h1
`define CCP_KIND_BR_WORD    3'h2
`define CCP_KIND_BR_LONG    3'h3

// Coprocessor access in CPU space: identifier on A15-A13, register on A4-A0
`define CCP_SPACE_BASE      18'h20000
`define CCP_COPROCESSOR_NUMBER_LSB        13
`define CCP_REG_RESPONSE    5'h00
`define CCP_REG_CONDITION   5'h0e

// Response primitive layout
`define CCP_PRIM_CA_BIT     15
`define CCP_PRIM_FN_MSB     12
`define CCP_PRIM_FN_LSB     8
`define CCP_PRIM_NULL_FN    5'h08
`define CCP_PRIM_TF_BIT     0

// Instruction stream
`define CCP_WORD_BYTES      32'h00000002
`define CCP_RESET_PC        32'h00000000

// Byte values written by the set operation
`define CCP_BYTE_FALSE      8'h00
`define CCP_BYTE_TRUE       8'hff

`endif

// file: hdl/ccp_pkg.sv
`default_nettype none
package ccp_pkg;

  typedef enum logic [3:0] {
    CCP_IDLE      = 4'h0,
    CCP_FETCH_SEL = 4'h1,
    CCP_WR_COND   = 4'h2,
    CCP_WR_REL    = 4'h3,
    CCP_RD_RESP   = 4'h4,
    CCP_RD_REL    = 4'h5,
    CCP_EVAL      = 4'h6,
    CCP_SERVICE   = 4'h7,
    CCP_SKIP      = 4'h8,
    CCP_FETCH_D1  = 4'h9,
    CCP_FETCH_D2  = 4'ha,
    CCP_FINISH    = 4'hb
  } ccp_state_type;

  typedef struct packed {
    logic [3:0] fline;
    logic [2:0] coprocessor_number;
    logic [2:0] kind;
    logic [5:0] selector;
  } ccp_opword_type;

  typedef struct packed {
    logic is_null;
    logic come_again;
    logic cond_true;
  } ccp_prim_type;

endpackage
`default_nettype wire

// file: hdl/ccp_prim_decode.sv
`include "ccp_cfg.svh"
`default_nettype none
module ccp_prim_decode (
  input  wire logic [15:0]          prim_word,
  output var  ccp_pkg::ccp_prim_type info
);
  import ccp_pkg::*;

  // Every primitive other than null is taken to allow the come-again attribute
  always_comb begin
    info.is_null    = (prim_word[`CCP_PRIM_FN_MSB:`CCP_PRIM_FN_LSB] == `CCP_PRIM_NULL_FN);
    info.come_again = prim_word[`CCP_PRIM_CA_BIT];
    info.cond_true  = prim_word[`CCP_PRIM_TF_BIT];
  end

endmodule
`default_nettype wire

// file: hdl/ccp_cond_seq.sv
`include "ccp_cfg.svh"
`default_nettype none
// Notes on behaviour
// - Start by writing selector to condition register
// - Then read response register, act on primitive
// - Finish only after true/false indicator arrives
// - Come-again: serve request, read response again
// - Non-null primitive lacking come-again: protocol violation
// - Branch word: 1111, id, size, selector fields
// - Branch writes whole operation word to register
// - Skip coprocessor extension words before displacement
// - False branch: continue with next instruction
// - True branch: target is scan counter plus displacement
// - Scan counter at first displacement word then
// - Word displacement sign-extended to 32 bits
// - Set word: id, pattern 001, address mode
// - Second set word: selector low six bits
// - Set writes second word to condition register
// - Consume zero to five address extension words; ea_ext_count allows up to seven
// - Set byte all zeros false, all ones true
module ccp_cond_seq (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire ccp_pkg::ccp_opword_type opword,
  input  wire logic [31:0]           opword_pc,
  input  wire logic [3:0]            ext_word_count,
  input  wire logic [2:0]            ea_ext_count,
  output logic                       fetch_req,
  output logic [31:0]                fetch_addr,
  input  wire logic                  fetch_valid,
  input  wire logic [15:0]           fetch_data,
  output logic                       cp_strobe,
  output logic                       cp_write,
  output logic [17:0]                cp_addr,
  output logic [15:0]                cp_wdata,
  input  wire logic                  cp_ack,
  input  wire logic [15:0]           cp_rdata,
  output logic                       svc_req,
  output logic [15:0]                svc_primitive,
  input  wire logic                  svc_done,
  output logic                       busy,
  output logic                       done,
  output logic [31:0]                next_pc,
  output logic                       byte_wr,
  output logic [7:0]                 byte_data,
  output logic                       protocol_violation,
  output logic                       not_conditional
);
  import ccp_pkg::*;

  ccp_state_type  state_reg;
  ccp_opword_type op_reg;
  ccp_prim_type   prim_info;
  logic [15:0]    prim_reg;
  logic [31:0]    scan_program_counter_reg;
  logic [31:0]    disp_pc_reg;
  logic [31:0]    disp_reg;
  logic           cond_true_reg;
  logic           ack_meta_reg;
  logic           ack_sync_reg;
  logic [15:0]    rdata_meta_reg;
  logic [15:0]    rdata_sync_reg;
  logic           op_ok;
  logic           op_branch;
  logic           op_set;
  logic           is_branch;
  logic           is_long;
  logic [31:0]    ext_bytes;
  logic [31:0]    ea_bytes;
  logic [31:0]    skip_pc;
  logic [31:0]    word_disp;

  ccp_prim_decode u_prim_decode (
    .prim_word (prim_reg),
    .info      (prim_info)
  );

  // Classify the incoming operation word
  always_comb begin
    op_ok     = (opword.fline == `CCP_FLINE_PATTERN);
    op_branch = op_ok && ((opword.kind == `CCP_KIND_BR_WORD) ||
                          (opword.kind == `CCP_KIND_BR_LONG));
    op_set    = op_ok && (opword.kind == `CCP_KIND_SET);
    is_branch = (op_reg.kind != `CCP_KIND_SET);
    is_long   = (op_reg.kind == `CCP_KIND_BR_LONG);
    ext_bytes = {27'h0, ext_word_count, 1'b0};
    ea_bytes  = {28'h0, ea_ext_count, 1'b0};
    // Branch stops at the displacement; set also walks the address extension words
    skip_pc   = is_branch ? scan_program_counter_reg + ext_bytes
                          : scan_program_counter_reg + ext_bytes + ea_bytes;
    word_disp = {{16{fetch_data[15]}}, fetch_data};
  end

  // Acknowledge and read data come from pins; data passes its own two-stage synchroniser alongside ack
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_meta_reg   <= 1'b0;
      ack_sync_reg   <= 1'b0;
      rdata_meta_reg <= 16'h0000;
      rdata_sync_reg <= 16'h0000;
    end else begin
      ack_meta_reg   <= cp_ack;
      ack_sync_reg   <= ack_meta_reg;
      rdata_meta_reg <= cp_rdata;
      rdata_sync_reg <= rdata_meta_reg;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= CCP_IDLE;
    end else begin
      unique case (state_reg)
        CCP_IDLE: begin
          if (start && op_branch) begin
            state_reg <= CCP_WR_COND;
          end else if (start && op_set) begin
            state_reg <= CCP_FETCH_SEL;
          end
        end
        CCP_FETCH_SEL: begin
          if (fetch_valid) begin
            state_reg <= CCP_WR_COND;
          end
        end
        CCP_WR_COND: begin
          if (ack_sync_reg) begin
            state_reg <= CCP_WR_REL;
          end
        end
        CCP_WR_REL: begin
          if (!ack_sync_reg) begin
            state_reg <= CCP_RD_RESP;
          end
        end
        CCP_RD_RESP: begin
          if (ack_sync_reg) begin
            state_reg <= CCP_RD_REL;
          end
        end
        CCP_RD_REL: begin
          if (!ack_sync_reg) begin
            state_reg <= CCP_EVAL;
          end
        end
        CCP_EVAL: begin
          if (prim_info.is_null) begin
            state_reg <= CCP_SKIP;
          end else if (!prim_info.come_again) begin
            state_reg <= CCP_IDLE;
          end else begin
            state_reg <= CCP_SERVICE;
          end
        end
        CCP_SERVICE: begin
          if (svc_done) begin
            state_reg <= CCP_RD_RESP;
          end
        end
        CCP_SKIP: begin
          state_reg <= is_branch ? CCP_FETCH_D1 : CCP_FINISH;
        end
        CCP_FETCH_D1: begin
          if (fetch_valid) begin
            state_reg <= is_long ? CCP_FETCH_D2 : CCP_FINISH;
          end
        end
        CCP_FETCH_D2: begin
          if (fetch_valid) begin
            state_reg <= CCP_FINISH;
          end
        end
        CCP_FINISH: begin
          state_reg <= CCP_IDLE;
        end
        default: begin
          state_reg <= CCP_IDLE;
        end
      endcase
    end
  end

  // Operation word, scan counter and displacement
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_reg                   <= '0;
      scan_program_counter_reg <= `CCP_RESET_PC;
      disp_pc_reg              <= `CCP_RESET_PC;
      disp_reg                 <= 32'h00000000;
    end else begin
      if (state_reg == CCP_IDLE && start) begin
        op_reg                   <= opword;
        scan_program_counter_reg <= opword_pc + `CCP_WORD_BYTES;
      end
      if (state_reg == CCP_FETCH_SEL && fetch_valid) begin
        scan_program_counter_reg <= scan_program_counter_reg + `CCP_WORD_BYTES;
      end
      if (state_reg == CCP_SKIP) begin
        scan_program_counter_reg <= skip_pc;
        disp_pc_reg              <= skip_pc;
      end
      if (state_reg == CCP_FETCH_D1 && fetch_valid) begin
        scan_program_counter_reg <= scan_program_counter_reg + `CCP_WORD_BYTES;
        disp_reg <= is_long ? {fetch_data, 16'h0000} : word_disp;
      end
      if (state_reg == CCP_FETCH_D2 && fetch_valid) begin
        scan_program_counter_reg <= scan_program_counter_reg + `CCP_WORD_BYTES;
        disp_reg[15:0]           <= fetch_data;
      end
    end
  end

  // Instruction stream requests; the address is held until the word arrives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fetch_req  <= 1'b0;
      fetch_addr <= `CCP_RESET_PC;
    end else begin
      if (state_reg == CCP_IDLE && start && op_set) begin
        fetch_req  <= 1'b1;
        fetch_addr <= opword_pc + `CCP_WORD_BYTES;
      end else if (state_reg == CCP_SKIP && is_branch) begin
        fetch_req  <= 1'b1;
        fetch_addr <= skip_pc;
      end else if (state_reg == CCP_FETCH_D1 && fetch_valid && is_long) begin
        fetch_req  <= 1'b1;
        fetch_addr <= fetch_addr + `CCP_WORD_BYTES;
      end else if (fetch_valid) begin
        fetch_req  <= 1'b0;
      end
    end
  end

  // Coprocessor accesses: strobe held until ack, then released before the next access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cp_strobe <= 1'b0;
      cp_write  <= 1'b0;
      cp_addr   <= `CCP_SPACE_BASE;
      cp_wdata  <= 16'h0000;
      prim_reg  <= 16'h0000;
    end else begin
      if (state_reg == CCP_IDLE && start && op_branch) begin
        cp_strobe <= 1'b1;
        cp_write  <= 1'b1;
        cp_addr   <= `CCP_SPACE_BASE |
                     (18'(opword.coprocessor_number) << `CCP_COPROCESSOR_NUMBER_LSB) |
                     18'(`CCP_REG_CONDITION);
        cp_wdata  <= opword;
      end else if (state_reg == CCP_FETCH_SEL && fetch_valid) begin
        cp_strobe <= 1'b1;
        cp_write  <= 1'b1;
        cp_addr   <= `CCP_SPACE_BASE |
                     (18'(op_reg.coprocessor_number) << `CCP_COPROCESSOR_NUMBER_LSB) |
                     18'(`CCP_REG_CONDITION);
        cp_wdata  <= fetch_data;
      end else if ((state_reg == CCP_WR_REL && !ack_sync_reg) ||
                   (state_reg == CCP_SERVICE && svc_done)) begin
        cp_strobe <= 1'b1;
        cp_write  <= 1'b0;
        cp_addr   <= `CCP_SPACE_BASE |
                     (18'(op_reg.coprocessor_number) << `CCP_COPROCESSOR_NUMBER_LSB) |
                     18'(`CCP_REG_RESPONSE);
      end else if ((state_reg == CCP_WR_COND || state_reg == CCP_RD_RESP) && ack_sync_reg) begin
        cp_strobe <= 1'b0;
      end
      if (state_reg == CCP_RD_RESP && ack_sync_reg) begin
        prim_reg <= rdata_sync_reg;
      end
    end
  end

  // Service requests toward the rest of the processor
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      svc_req       <= 1'b0;
      svc_primitive <= 16'h0000;
    end else begin
      svc_req <= (state_reg == CCP_EVAL) && !prim_info.is_null && prim_info.come_again;
      if (state_reg == CCP_EVAL) begin
        svc_primitive <= prim_reg;
      end
    end
  end

  // Completion, outcome and error pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cond_true_reg      <= 1'b0;
      busy               <= 1'b0;
      done               <= 1'b0;
      next_pc            <= `CCP_RESET_PC;
      byte_wr            <= 1'b0;
      byte_data          <= `CCP_BYTE_FALSE;
      protocol_violation <= 1'b0;
      not_conditional    <= 1'b0;
    end else begin
      busy <= (state_reg != CCP_IDLE) ? !(state_reg == CCP_FINISH ||
              (state_reg == CCP_EVAL && !prim_info.is_null && !prim_info.come_again))
              : (start && (op_branch || op_set));
      if (state_reg == CCP_EVAL && prim_info.is_null) begin
        cond_true_reg <= prim_info.cond_true;
      end
      protocol_violation <= (state_reg == CCP_EVAL) && !prim_info.is_null &&
                            !prim_info.come_again;
      not_conditional <= (state_reg == CCP_IDLE) && start && !op_branch && !op_set;
      done    <= (state_reg == CCP_FINISH);
      byte_wr <= (state_reg == CCP_FINISH) && !is_branch;
      if (state_reg == CCP_FINISH) begin
        if (is_branch && cond_true_reg) begin
          next_pc <= disp_pc_reg + disp_reg;
        end else begin
          next_pc <= scan_program_counter_reg;
        end
        byte_data <= cond_true_reg ? `CCP_BYTE_TRUE : `CCP_BYTE_FALSE;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/ccp_cond_sva.sv
`default_nettype none
module ccp_cond_sva
  import ccp_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    start,
  input wire ccp_pkg::ccp_opword_type opword,
  input wire logic [31:0]             opword_pc,
  input wire logic                    fetch_req,
  input wire logic [31:0]             fetch_addr,
  input wire logic                    cp_strobe,
  input wire logic                    cp_write,
  input wire logic [17:0]             cp_addr,
  input wire logic [15:0]             cp_wdata,
  input wire logic                    cp_ack,
  input wire logic [15:0]             cp_rdata,
  input wire logic                    svc_req,
  input wire logic [15:0]             svc_primitive,
  input wire logic                    busy,
  input wire logic                    done,
  input wire logic                    byte_wr,
  input wire logic [7:0]              byte_data,
  input wire logic                    protocol_violation,
  input wire logic                    not_conditional
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccp_pkg::*;
  logic [15:0] last_rd_reg;
  logic [2:0]  coprocessor_number_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Captured at the raw ack; the design acts on it only after its synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_rd_reg <= 16'h0000;
    end else if (cp_strobe && cp_ack && !cp_write) begin
      last_rd_reg <= cp_rdata;
    end
  end
  // Coprocessor number of the instruction in progress, for full address checks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coprocessor_number_reg <= 3'h0;
    end else if (start && !busy) begin
      coprocessor_number_reg <= opword.coprocessor_number;
    end
  end
  sequence s_start;
    start && !busy;
  endsequence
  sequence s_acked;
    $rose(cp_ack) ##0 cp_strobe;
  endsequence
  a_br_cond_write: assert property (
    s_start ##0 opword.fline == 4'hf && opword.kind inside {3'h2, 3'h3} |=> cp_strobe
    && cp_write && cp_wdata == $past(opword)
    && cp_addr == (18'h20000 | {$past(opword.coprocessor_number), 13'h000e}))
    else $error("branch did not write its operation word");
  a_set_fetch_first: assert property (
    s_start ##0 opword.fline == 4'hf && opword.kind == 3'h1 |=> fetch_req && !cp_strobe
    && fetch_addr == $past(opword_pc) + 32'h2)
    else $error("set did not fetch its second word first");
  a_not_cond: assert property (
    s_start ##0 !(opword.fline == 4'hf && opword.kind inside {3'h1, 3'h2, 3'h3})
    |=> not_conditional && !busy)
    else $error("foreign operation word not refused");
  a_reg_select: assert property (
    $rose(cp_strobe) |-> cp_addr == {2'h2, coprocessor_number_reg, 8'h00, (cp_write ? 5'h0e : 5'h00)})
    else $error("wrong interface register");
  a_strobe_hold: assert property (
    cp_strobe && !cp_ack |=> cp_strobe && $stable(cp_addr) && $stable(cp_wdata))
    else $error("access released before ack");
  a_ack_release: assert property (
    s_acked |-> ##[1:4] !cp_strobe)
    else $error("strobe held after ack");
  a_done_null: assert property (
    done |-> last_rd_reg[12:8] == 5'h08 ##1 !done)
    else $error("completion without null primitive");
  a_byte_value: assert property (
    byte_wr |-> done && byte_data == {8{last_rd_reg[0]}})
    else $error("set byte does not follow indicator");
  a_svc_ca: assert property (
    svc_req |-> last_rd_reg[15] && svc_primitive == last_rd_reg)
    else $error("service asked without come-again");
  a_viol_abort: assert property (
    protocol_violation |-> !last_rd_reg[15] && last_rd_reg[12:8] != 5'h08 && !done ##1 !busy)
    else $error("violation not tied to missing come-again");
endmodule
`default_nettype wire

// file: tb/ccp_coproc_model.sv
`default_nettype none
module ccp_coproc_model (
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         cp_strobe,
  input wire logic         cp_write,
  input wire logic [15:0]  cp_wdata,
  output logic             cp_ack,
  output logic [15:0]      cp_rdata,
  input wire logic [1:0]   n_ca,
  input wire logic [1:0]   dly,
  input wire logic         bad,
  output logic [15:0]      cond_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg;
  logic [1:0] seen_reg;
  logic       cond_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cp_ack <= 1'b0;
      cp_rdata <= 16'h0000;
      cond_word <= 16'h0000;
      wait_reg <= 2'h0;
      seen_reg <= 2'h0;
      cond_reg <= 1'b0;
    end else if (cp_strobe && !cp_ack) begin
      if (wait_reg != dly) begin
        wait_reg <= wait_reg + 2'h1;
      end else begin
        cp_ack <= 1'b1;
        wait_reg <= 2'h0;
        if (cp_write) begin
          cond_word <= cp_wdata;
          cond_reg <= cp_wdata[0];
          seen_reg <= 2'h0;
        end else if (seen_reg != n_ca) begin
          cp_rdata <= 16'h8100;
          seen_reg <= seen_reg + 2'h1;
        end else begin
          cp_rdata <= bad ? 16'h0100 : {15'h0400, cond_reg};
        end
      end
    end else if (!cp_strobe && cp_ack) begin
      cp_ack <= 1'b0;
      // Released data must not look like the last answer
      cp_rdata <= ~cp_rdata;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  logic           start = 1'b0;
  ccp_opword_type opword = '0;
  logic [31:0]    opword_pc = 32'h00000100;
  logic [3:0]     ext_word_count = 4'h0;
  logic [2:0]     ea_ext_count = 3'h0;
  logic           fetch_valid = 1'b0;
  logic [15:0]    fetch_data = 16'h0000;
  logic           svc_done = 1'b0;
  logic [1:0]     n_ca = 2'h0;
  logic [1:0]     dly = 2'h0;
  logic           bad = 1'b0;
  logic           fetch_req, cp_strobe, cp_write, cp_ack, svc_req, busy, done, byte_wr;
  logic           protocol_violation, not_conditional;
  logic [31:0]    fetch_addr, next_pc;
  logic [17:0]    cp_addr;
  logic [15:0]    cp_wdata, cp_rdata, svc_primitive, cond_word;
  logic [7:0]     byte_data;
  logic [15:0]    iw [0:15];
  int             n_mismatch = 0;
  int             total_checks = 0;
  int             n_svc = 0;
  always #2.5 core_clk = ~core_clk;
  // Instruction memory answers one cycle late; idle data toggles
  always @(posedge core_clk) begin
    fetch_valid <= fetch_req && !fetch_valid;
    fetch_data <= fetch_req ? iw[4'((fetch_addr - opword_pc) >> 1)] : ~fetch_data;
    svc_done <= svc_req;
    if (svc_req) n_svc <= n_svc + 1;
  end
  ccp_cond_seq u_ccp_cond_seq (
    .core_clk, .rst, .start, .opword, .opword_pc, .ext_word_count, .ea_ext_count,
    .fetch_req, .fetch_addr, .fetch_valid, .fetch_data, .cp_strobe, .cp_write, .cp_addr,
    .cp_wdata, .cp_ack, .cp_rdata, .svc_req, .svc_primitive, .svc_done, .busy, .done,
    .next_pc, .byte_wr, .byte_data, .protocol_violation, .not_conditional
  );
  ccp_coproc_model u_ccp_coproc_model (
    .core_clk, .rst, .cp_strobe, .cp_write, .cp_wdata, .cp_ack, .cp_rdata, .n_ca, .dly,
    .bad, .cond_word
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [15:0] op);
    int i;
    @(posedge core_clk);
    opword <= op;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (i = 0; i < 500; i++) begin
      @(negedge core_clk);
      if ((done | protocol_violation | not_conditional) === 1'b1) break;
    end
  endtask
  task automatic t_branch(input logic [2:0] kind, input logic [5:0] sel,
                          input logic [31:0] disp, input logic [3:0] ext, input logic [1:0] ca);
    logic [15:0] op;
    logic [31:0] dpc;
    logic [31:0] exp;
    int          s0;
    int          k;
    op = {4'hf, 3'h3, kind, sel};
    dpc = opword_pc + 32'h2 + {27'h0, ext, 1'b0};
    for (k = 1; k < 16; k++) iw[k] = 16'h5a5a;
    iw[ext + 4'h1] = (kind == 3'h2) ? disp[15:0] : disp[31:16];
    iw[ext + 4'h2] = disp[15:0];
    if (!sel[0]) exp = dpc + ((kind == 3'h2) ? 32'h2 : 32'h4);
    else if (kind == 3'h2) exp = dpc + {{16{disp[15]}}, disp[15:0]};
    else exp = dpc + disp;
    @(posedge core_clk);
    ext_word_count <= ext;
    n_ca <= ca;
    s0 = n_svc;
    go(op);
    chk(done, 32'h1);
    chk(next_pc, exp);
    chk(byte_wr, 32'h0);
    chk(cond_word, op);
    chk(n_svc - s0, ca);
    $display("t_branch kind %h sel %h finished", kind, sel);
  endtask
  task automatic t_set(input logic [5:0] sel, input logic [3:0] ext, input logic [2:0] ea);
    logic [31:0] exp;
    iw[1] = {10'h000, sel};
    exp = opword_pc + 32'h4 + {27'h0, ext, 1'b0} + {28'h0, ea, 1'b0};
    @(posedge core_clk);
    ext_word_count <= ext;
    ea_ext_count <= ea;
    n_ca <= 2'h1;
    go({4'hf, 3'h6, 3'h1, 6'h15});
    chk(byte_wr, 32'h1);
    chk(byte_data, sel[0] ? 32'hff : 32'h0);
    chk(next_pc, exp);
    chk(cond_word, iw[1]);
    $display("t_set sel %h finished", sel);
  endtask
  task automatic t_bad;
    @(posedge core_clk);
    n_ca <= 2'h1;
    bad <= 1'b1;
    go({4'hf, 3'h1, 3'h2, 6'h01});
    chk(protocol_violation, 32'h1);
    chk(done, 32'h0);
    @(negedge core_clk);
    chk(busy, 32'h0);
    @(posedge core_clk);
    bad <= 1'b0;
    $display("t_bad finished");
  endtask
  task automatic t_notcond;
    int i;
    for (i = 0; i < 9; i++) begin
      if (i < 1 || i > 3) begin
        go(i == 8 ? 16'he481 : {4'hf, 3'h2, i[2:0], 6'h01});
        chk(not_conditional, 32'h1);
        chk(busy, 32'h0);
      end
    end
    $display("t_notcond finished");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_branch(3'h2, 6'h01, 32'h0000fff0, 4'h2, 2'h2);
    t_branch(3'h2, 6'h02, 32'h00000010, 4'h0, 2'h0);
    @(posedge core_clk);
    dly <= 2'h3;
    t_branch(3'h3, 6'h03, 32'h00012340, 4'h1, 2'h1);
    t_branch(3'h3, 6'h00, 32'hfffffe00, 4'h0, 2'h0);
    t_set(6'h01, 4'h1, 3'h5);
    t_set(6'h3e, 4'h0, 3'h0);
    t_bad;
    t_notcond;
    results();
  end
  // Whole run needs a few hundred cycles; this 20000-cycle limit is many times that
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
bind ccp_cond_seq ccp_cond_sva u_ccp_cond_sva (
  .core_clk, .rst, .start, .opword, .opword_pc, .fetch_req, .fetch_addr, .cp_strobe,
  .cp_write, .cp_addr, .cp_wdata, .cp_ack, .cp_rdata, .svc_req, .svc_primitive, .busy,
  .done, .byte_wr, .byte_data, .protocol_violation, .not_conditional
);
`default_nettype wire
